// [common/ctsl_defines.svh]
// constants for the charger thermal and status logic
`ifndef CTSL_DEFINES_SVH
`define CTSL_DEFINES_SVH
`define CTSL_CLK_MHZ 10
// apb byte addresses
`define CTSL_A_CFG 12'h000
`define CTSL_A_STAT 12'h004
`define CTSL_A_IRQ 12'h008
`define CTSL_A_CFG7 12'h01c
// config register fields
`define CTSL_CFG_TPE 0
`define CTSL_CFG_WARM 1
`define CTSL_CFG_COOL 2
`define CTSL_CFG_QEN 3
`define CTSL_CFG_UTH_HI 5
`define CTSL_CFG_UDB 6
`define CTSL_CFG_EXT 7
`define CTSL_CFG_LED_LO 8
`define CTSL_CFG_VARB 10
`define CTSL_CFG_ADAPTIVE_INPUT_LIMIT 11
`define CTSL_CFG_MODE_LO 12
`define CTSL_CFG_U5V 16
`define CTSL_CFG_W 17
`define CTSL_CFG_RST 17'h00001
`define CTSL_SHIP_BIT 0
`define CTSL_IRQ_BIT 0
// charge detail codes, voltage drop codes and boost mode codes
`define CTSL_DTL_OK 4'h0
`define CTSL_DTL_NOBAT 4'h8
`define CTSL_DTL_SUSP 4'h9
`define CTSL_CVD_NONE 2'h0
`define CTSL_CVD_A 2'h1
`define CTSL_CVD_B 2'h2
`define CTSL_MODE_BOOST 4'h9
`define CTSL_MODE_OTG 4'ha
// timing figures
`define CTSL_IULO_DEB_US 1000
`define CTSL_EXIT_DEB0_US 2000
`define CTSL_EXIT_DEB1_US 8000
`define CTSL_UNPLUG_DEB0_US 100
`define CTSL_UNPLUG_DEB1_US 1000
`define CTSL_LED_PERIOD_MS 1000
// synchronised pin vector layout
`define CTSL_NSYNC 20
`define CTSL_S_COLD 0
`define CTSL_S_COOL 1
`define CTSL_S_WARM 2
`define CTSL_S_HOT 3
`define CTSL_S_REM 4
`define CTSL_S_GND 5
`define CTSL_S_ADP 6
`define CTSL_S_BUCK 7
`define CTSL_S_BTN 8
`define CTSL_S_UCMP 9
`define CTSL_S_AREG 10
`define CTSL_S_ILOW 11
`define CTSL_S_C2S 12
`define CTSL_S_UV80 13
`define CTSL_S_SUSP 14
`define CTSL_S_DEEP 15
`define CTSL_S_PH_LO 16
`endif

// [common/ctsl_pkg.sv]
// types for the charger thermal and status logic
`include "ctsl_defines.svh"
package ctsl_pkg;
    typedef enum logic [2:0] {
        CTSL_Z_NORM = 3'h0,
        CTSL_Z_COOL = 3'h1,
        CTSL_Z_COLD = 3'h3,
        CTSL_Z_WARM = 3'h4,
        CTSL_Z_HOT = 3'h6,
        CTSL_Z_REM = 3'h7,
        CTSL_Z_DIS = 3'h2
    } ctsl_zone_type;

    typedef enum logic [3:0] {
        CTSL_PH_IDLE = 4'h0,
        CTSL_PH_DBAT = 4'h1,
        CTSL_PH_PREQ = 4'h3,
        CTSL_PH_CC = 4'h2,
        CTSL_PH_CV = 4'h6,
        CTSL_PH_TOPOFF = 4'h7,
        CTSL_PH_DONE = 4'h5,
        CTSL_PH_RESTART = 4'h4,
        CTSL_PH_TIMEOUT = 4'hc,
        CTSL_PH_TSHDN = 4'hd
    } ctsl_phase_type;

    typedef struct packed {
        logic [`CTSL_NSYNC-1:0] s1;
        logic [`CTSL_NSYNC-1:0] s2;
        logic [`CTSL_CFG_W-1:0] cfg;
        logic ship;
        logic irq;
        logic susp;
        logic nobat;
        ctsl_zone_type zone;
        logic [23:0] exit_cnt;
        logic [23:0] pg_cnt;
        logic [23:0] iulo_cnt;
        logic [23:0] led_cnt;
        logic pg_filt;
        logic chg_en;
        logic restart;
        logic cc_half;
        logic cc_warm;
        logic cv_cool;
        logic [1:0] cvd;
        logic qb_oe;
        logic led;
        logic rdy;
        logic [31:0] rdata;
        logic err;
    } ctsl_state_type;
endpackage

// [design/ctsl_top.sv]
// charger thermal zones, ship mode, switch drive, power good and led
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ctsl_defines.svh"

// Summary of operation
// - below cold or above hot: stop charge, reset timers, report, flag irq
// - back inside cold..hot: resume charging, restart charge timer
// - thermistor pin pulled to rail means battery gone; charging inhibited
// - grounded thermistor pin: no monitoring, battery assumed, auto charge
// - temperature profile disabled: zones ignored for charge decisions, pin at rail still stops charge
// - warm zone: fast charge current from warm current select bit
// - cool zone: termination voltage from cool voltage select bit
// - cool zone: fast charge current halved
// - warm zone: termination voltage lowered 187.5mV or 375mV by variant
// - charge current halved by profile: safety timer doubled
// - writing 1 to bit 0 of config seven enters ship mode
// - ship mode left on removal, charger plug or debounced exit button
// - ship mode cannot be entered with a valid charger present
// - switch drive low in battery mode, released with adapter and buck switching or mode 9/A
// - switch drive output enabled or disabled by its control bit
// - unplug threshold 0b10/0b11: switch pin shows power good instead
// - 9V/15V: power good follows threshold comparator with select debounce
// - 5V adaptive on: released at regulation with low current for 1ms
// - 5V adaptive off: released on headroom trip or input under 80% uvlo
// - power good low only with adapter valid and the selected source good, not ship/deep/boost modes
// - led sink current 5mA to 20mA in 5mA steps from a select field
module ctsl_top
    import ctsl_pkg::*;
#(
    parameter int unsigned IULO_DEB_CYC =
        `CTSL_IULO_DEB_US * `CTSL_CLK_MHZ,
    parameter int unsigned EXIT_DEB0_CYC =
        `CTSL_EXIT_DEB0_US * `CTSL_CLK_MHZ,
    parameter int unsigned EXIT_DEB1_CYC =
        `CTSL_EXIT_DEB1_US * `CTSL_CLK_MHZ,
    parameter int unsigned UNPLUG_DEB0_CYC =
        `CTSL_UNPLUG_DEB0_US * `CTSL_CLK_MHZ,
    parameter int unsigned UNPLUG_DEB1_CYC =
        `CTSL_UNPLUG_DEB1_US * `CTSL_CLK_MHZ,
    parameter int unsigned LED_PERIOD_CYC =
        `CTSL_LED_PERIOD_MS * 1000 * `CTSL_CLK_MHZ
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic thm_below_cold,
    input wire logic thm_below_cool,
    input wire logic thm_above_warm,
    input wire logic thm_above_hot,
    input wire logic thermistor_sense_pin_at_rail,
    input wire logic thermistor_sense_pin_grounded,
    input wire logic adapter_valid,
    input wire logic buck_switching,
    input wire logic ship_exit_button,
    input wire logic unplug_cmp_above,
    input wire logic chgin_at_reg,
    input wire logic chgin_current_low,
    input wire logic headroom_trip,
    input wire logic chgin_below_uvlo80,
    input wire logic suspend_mode,
    input wire logic deep_suspend_mode,
    input wire logic [3:0] charge_phase,
    output logic charge_enable,
    output logic charge_timer_restart,
    output logic cc_half,
    output logic cc_warm_use,
    output logic warm_current_select,
    output logic cv_cool_use,
    output logic cool_voltage_select,
    output logic [1:0] cv_drop_code,
    output logic timer_double,
    output logic ship_mode,
    output logic ext_switch_drive_pin_o,
    output logic ext_switch_drive_pin_oe,
    output logic led_on,
    output logic [1:0] led_current_select
);
    ctsl_state_type q;
    ctsl_state_type d;
    logic [`CTSL_NSYNC-1:0] raw;

    ////////////////////////////////////////////////////////////////////
    // pin vector, all of it foreign to pclk
    assign raw = {charge_phase, deep_suspend_mode, suspend_mode,
        chgin_below_uvlo80, headroom_trip, chgin_current_low,
        chgin_at_reg, unplug_cmp_above, ship_exit_button,
        buck_switching, adapter_valid, thermistor_sense_pin_grounded,
        thermistor_sense_pin_at_rail, thm_above_hot, thm_above_warm,
        thm_below_cool, thm_below_cold};

    // boost or boost plus otg mode codes
    function automatic logic is_boost(input logic [3:0] m);
        is_boost = (m == `CTSL_MODE_BOOST) || (m == `CTSL_MODE_OTG);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        logic gnd;
        logic rem;
        logic adp;
        logic mon;
        logic acc;
        logic wr_hit;
        logic irq_clr;
        logic exit_fire;
        logic [23:0] lim;
        logic iulo_trip;
        logic good;
        logic pg_drive;
        logic qb_drive;
        logic boost;
        logic b1;
        logic b2;
        logic [23:0] half;
        logic [23:0] qtr;
        gnd = 1'b0;
        rem = 1'b0;
        adp = 1'b0;
        mon = 1'b0;
        acc = 1'b0;
        wr_hit = 1'b0;
        irq_clr = 1'b0;
        exit_fire = 1'b0;
        lim = 24'h0;
        iulo_trip = 1'b0;
        good = 1'b0;
        pg_drive = 1'b0;
        qb_drive = 1'b0;
        boost = 1'b0;
        b1 = 1'b0;
        b2 = 1'b0;
        half = 24'h0;
        qtr = 24'h0;
        d = q;
        // two-flop synchroniser; only s2 is looked at
        d.s1 = raw;
        d.s2 = q.s1;
        gnd = q.s2[`CTSL_S_GND];
        rem = q.s2[`CTSL_S_REM] && !gnd;
        adp = q.s2[`CTSL_S_ADP];
        boost = is_boost(q.cfg[`CTSL_CFG_MODE_LO +: 4]);

        // zone classification; grounded pin never reports removal
        mon = q.cfg[`CTSL_CFG_TPE] && !gnd;
        if (rem)
            d.zone = CTSL_Z_REM;
        else if (!mon)
            d.zone = CTSL_Z_DIS;
        else if (q.s2[`CTSL_S_COLD])
            d.zone = CTSL_Z_COLD;
        else if (q.s2[`CTSL_S_HOT])
            d.zone = CTSL_Z_HOT;
        else if (q.s2[`CTSL_S_COOL])
            d.zone = CTSL_Z_COOL;
        else if (q.s2[`CTSL_S_WARM])
            d.zone = CTSL_Z_WARM;
        else
            d.zone = CTSL_Z_NORM;

        // suspend and timer restart on either edge of it
        d.susp = (d.zone == CTSL_Z_COLD) || (d.zone == CTSL_Z_HOT);
        d.nobat = (d.zone == CTSL_Z_REM);
        d.restart = d.susp != q.susp;
        d.chg_en = adp && !d.susp && !d.nobat;

        // current and voltage profile
        d.cc_half = d.zone == CTSL_Z_COOL;
        d.cv_cool = d.zone == CTSL_Z_COOL;
        d.cc_warm = d.zone == CTSL_Z_WARM;
        if (d.zone == CTSL_Z_WARM)
            d.cvd = q.cfg[`CTSL_CFG_VARB] ? `CTSL_CVD_B : `CTSL_CVD_A;
        else
            d.cvd = `CTSL_CVD_NONE;

        // exit button must stay high for the selected time
        lim = q.cfg[`CTSL_CFG_EXT] ? 24'(EXIT_DEB1_CYC) :
            24'(EXIT_DEB0_CYC);
        if (!q.s2[`CTSL_S_BTN])
            d.exit_cnt = 24'h0;
        else if (q.exit_cnt < lim)
            d.exit_cnt = q.exit_cnt + 24'h1;
        exit_fire = q.exit_cnt >= lim;
        if (q.ship && (rem || adp || exit_fire))
            d.ship = 1'b0;

        // unplug comparator filter, restarts on every bounce
        lim = q.cfg[`CTSL_CFG_UDB] ? 24'(UNPLUG_DEB1_CYC) :
            24'(UNPLUG_DEB0_CYC);
        if (q.s2[`CTSL_S_UCMP] == q.pg_filt)
            d.pg_cnt = 24'h0;
        else if (q.pg_cnt >= lim)
        begin
            d.pg_cnt = 24'h0;
            d.pg_filt = q.s2[`CTSL_S_UCMP];
        end
        else
            d.pg_cnt = q.pg_cnt + 24'h1;

        // low input current at regulation, timed
        if (!(q.s2[`CTSL_S_AREG] && q.s2[`CTSL_S_ILOW]))
            d.iulo_cnt = 24'h0;
        else if (q.iulo_cnt < 24'(IULO_DEB_CYC))
            d.iulo_cnt = q.iulo_cnt + 24'h1;
        iulo_trip = q.iulo_cnt >= 24'(IULO_DEB_CYC);

        // power good source selection
        if (!q.cfg[`CTSL_CFG_U5V])
            good = q.pg_filt;
        else if (q.cfg[`CTSL_CFG_ADAPTIVE_INPUT_LIMIT])
            good = !iulo_trip;
        else
            good = !(q.s2[`CTSL_S_C2S] || q.s2[`CTSL_S_UV80]);
        pg_drive = adp && good && !q.ship && !q.s2[`CTSL_S_DEEP] &&
            !boost;
        // battery mode only; adapter with buck running releases it
        qb_drive = q.cfg[`CTSL_CFG_QEN] &&
            !(adp && q.s2[`CTSL_S_BUCK]) && !boost;
        d.qb_oe = q.cfg[`CTSL_CFG_UTH_HI] ? pg_drive : qb_drive;

        // led blink timebase, one full second per wrap
        if (q.led_cnt >= 24'(LED_PERIOD_CYC - 1))
            d.led_cnt = 24'h0;
        else
            d.led_cnt = q.led_cnt + 24'h1;
        half = 24'(LED_PERIOD_CYC / 2);
        qtr = 24'(LED_PERIOD_CYC / 4);
        b1 = q.led_cnt < half;
        b2 = (q.led_cnt < qtr) ||
            ((q.led_cnt >= half) && (q.led_cnt < half + qtr));
        if (!adp || q.s2[`CTSL_S_SUSP])
            d.led = 1'b0;
        else if (q.susp)
            d.led = b2;
        else
        begin
            case (ctsl_phase_type'(q.s2[`CTSL_S_PH_LO +: 4]))
                CTSL_PH_TIMEOUT, CTSL_PH_TSHDN: d.led = b2;
                CTSL_PH_DBAT, CTSL_PH_PREQ,
                CTSL_PH_CC, CTSL_PH_CV: d.led = b1;
                CTSL_PH_TOPOFF, CTSL_PH_DONE,
                CTSL_PH_RESTART: d.led = 1'b1;
                default: d.led = 1'b0;
            endcase
        end

        // apb: answer prepared in setup, pready high in the access phase
        acc = psel && penable && q.rdy;
        wr_hit = acc && pwrite;
        d.rdy = psel && !penable;
        d.err = 1'b0;
        d.rdata = 32'h0;
        if (psel && !penable)
        begin
            case (paddr)
                `CTSL_A_CFG: d.rdata = 32'(q.cfg);
                `CTSL_A_STAT: d.rdata = {23'h0, q.ship, q.zone,
                    !(q.susp || q.nobat),
                    q.susp ? `CTSL_DTL_SUSP :
                    (q.nobat ? `CTSL_DTL_NOBAT : `CTSL_DTL_OK)};
                `CTSL_A_IRQ: d.rdata = {31'h0, q.irq};
                `CTSL_A_CFG7: d.rdata = {31'h0, q.ship};
                default: d.err = 1'b1;
            endcase
        end
        if (wr_hit && (paddr == `CTSL_A_CFG))
            d.cfg = pwdata[`CTSL_CFG_W-1:0];
        irq_clr = wr_hit && (paddr == `CTSL_A_IRQ) &&
            pwdata[`CTSL_IRQ_BIT];
        // a new suspend in the clearing cycle keeps the flag set
        d.irq = (q.irq && !irq_clr) || (d.susp && !q.susp);
        // a present charger blocks entry outright
        if (wr_hit && (paddr == `CTSL_A_CFG7) &&
            pwdata[`CTSL_SHIP_BIT] && !adp)
            d.ship = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.cfg <= `CTSL_CFG_RST;
            q.zone <= CTSL_Z_NORM;
        end
        else
            q <= d;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all but the constant switch drive level from the state register
    assign pready = q.rdy;
    assign prdata = q.rdata;
    assign pslverr = q.err;
    assign charge_enable = q.chg_en;
    assign charge_timer_restart = q.restart;
    assign cc_half = q.cc_half;
    assign timer_double = q.cc_half;
    assign cc_warm_use = q.cc_warm;
    assign warm_current_select = q.cfg[`CTSL_CFG_WARM];
    assign cv_cool_use = q.cv_cool;
    assign cool_voltage_select = q.cfg[`CTSL_CFG_COOL];
    assign cv_drop_code = q.cvd;
    assign ship_mode = q.ship;
    // open drain: only ever pulls low
    assign ext_switch_drive_pin_o = 1'b0;
    assign ext_switch_drive_pin_oe = q.qb_oe;
    assign led_on = q.led;
    assign led_current_select = q.cfg[`CTSL_CFG_LED_LO +: 2];

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_susp_stop;
        (q.zone == CTSL_Z_COLD || q.zone == CTSL_Z_HOT) |-> !charge_enable;
    endproperty
    a_susp_stop: assert property (p_susp_stop)
        else $error("charging while temperature out of range");

    property p_irq_set;
        (!q.susp ##1 q.susp) |-> q.irq;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("suspend did not raise the charger flag");

    property p_restart;
        $changed(q.susp) |-> charge_timer_restart ##1
            (charge_timer_restart == $changed(q.susp));
    endproperty
    a_restart: assert property (p_restart)
        else $error("timer restart missing on suspend change");

    property p_removed;
        q.nobat |-> !charge_enable && q.zone == CTSL_Z_REM;
    endproperty
    a_removed: assert property (p_removed)
        else $error("charging with battery removed");

    property p_grounded;
        q.s2[`CTSL_S_GND] |=> q.zone == CTSL_Z_DIS && !q.susp;
    endproperty
    a_grounded: assert property (p_grounded)
        else $error("grounded thermistor still monitored");

    property p_cool;
        q.zone == CTSL_Z_COOL |-> cc_half && timer_double && cv_cool_use;
    endproperty
    a_cool: assert property (p_cool)
        else $error("cool zone without halved current");

    property p_warm_b;
        d.zone == CTSL_Z_WARM && q.cfg[`CTSL_CFG_VARB] |=>
            cv_drop_code == `CTSL_CVD_B && cc_warm_use;
    endproperty
    a_warm_b: assert property (p_warm_b)
        else $error("warm zone voltage drop wrong");

    property p_no_ship;
        q.s2[`CTSL_S_ADP] |=> !ship_mode;
    endproperty
    a_no_ship: assert property (p_no_ship)
        else $error("ship mode held with charger present");

    property p_boost_rel;
        is_boost(q.cfg[`CTSL_CFG_MODE_LO +: 4]) |=> !ext_switch_drive_pin_oe;
    endproperty
    a_boost_rel: assert property (p_boost_rel)
        else $error("switch pin driven in boost mode");

    property p_pg_ship;
        ship_mode && q.cfg[`CTSL_CFG_UTH_HI] |=> !ext_switch_drive_pin_oe;
    endproperty
    a_pg_ship: assert property (p_pg_ship)
        else $error("power good driven in ship mode");
endmodule

// [testbench/ctsl_pack_model.sv]
// battery pack and thermistor divider model feeding the zone comparators
`timescale 1ns/1ps
module ctsl_pack_model
(
    input wire logic [2:0] temp_zone,
    output logic below_cold,
    output logic below_cool,
    output logic above_warm,
    output logic above_hot,
    output logic at_rail,
    output logic grounded
);
    // zones: 0 normal, 1 cool, 2 cold, 3 warm, 4 hot, 5 pack out, 6 pin tied
    // a removed pack reads as far too cold and a tied pin as far too hot,
    // so the cold and cool, or the warm and hot, comparators trip as on the real divider
    assign at_rail = (temp_zone == 3'h5);
    assign grounded = (temp_zone == 3'h6);
    assign below_cold = (temp_zone == 3'h2) || at_rail;
    assign below_cool = (temp_zone == 3'h1) || below_cold;
    assign above_hot = (temp_zone == 3'h4) || grounded;
    assign above_warm = (temp_zone == 3'h3) || above_hot;
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the charger thermal and status logic
`timescale 1ns/1ps
`include "ctsl_defines.svh"
module tb_top
    import ctsl_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic rerr, cold, cool, warm, hot, rail, gnd;
    logic [2:0] temp_zone;
    logic adapter_valid, buck_switching, ship_exit_button, unplug_cmp_above;
    logic chgin_at_reg, chgin_current_low, headroom_trip, chgin_below_uvlo80;
    logic suspend_mode, deep_suspend_mode, charge_enable, charge_timer_restart;
    logic cc_half, cc_warm_use, warm_current_select, cv_cool_use, led_on;
    logic cool_voltage_select, timer_double, ship_mode;
    logic ext_switch_drive_pin_o, ext_switch_drive_pin_oe;
    logic [3:0] charge_phase;
    logic [1:0] cv_drop_code, led_current_select;
    int n_errors, comparisons, base;
    int n_restart = 0;

    ////////////////////////////////////////////////////////////////////////
    // short debounce and led figures keep the run brief
    ctsl_top #(.IULO_DEB_CYC(8), .EXIT_DEB0_CYC(10), .EXIT_DEB1_CYC(20),
        .UNPLUG_DEB1_CYC(8), .LED_PERIOD_CYC(16))
    i_ctsl_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .thm_below_cold(cold),
        .thm_below_cool(cool), .thm_above_warm(warm), .thm_above_hot(hot),
        .thermistor_sense_pin_at_rail(rail),
        .thermistor_sense_pin_grounded(gnd), .adapter_valid,
        .buck_switching, .ship_exit_button, .unplug_cmp_above, .chgin_at_reg,
        .chgin_current_low, .headroom_trip, .chgin_below_uvlo80,
        .suspend_mode, .deep_suspend_mode, .charge_phase, .charge_enable,
        .charge_timer_restart, .cc_half, .cc_warm_use, .warm_current_select,
        .cv_cool_use, .cool_voltage_select, .cv_drop_code, .timer_double,
        .ship_mode, .ext_switch_drive_pin_o, .ext_switch_drive_pin_oe,
        .led_on, .led_current_select);
    ctsl_pack_model i_ctsl_pack_model (.temp_zone, .below_cold(cold),
        .below_cool(cool), .above_warm(warm), .above_hot(hot),
        .at_rail(rail), .grounded(gnd));

    // clock and a count of timer restart pulses
    always #50 pclk = ~pclk;
    always @(posedge pclk)
        if (charge_timer_restart === 1'b1)
            n_restart <= n_restart + 1;

    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; the request holds until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
        begin
            n_errors++;
            report_and_stop();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        apb(1'b0, a, 32'h0);
        chk_word(rdata, exp);
        chk_bit(rerr, eerr);
    endtask
    task zone(input logic [2:0] z);
        @(posedge pclk);
        temp_zone <= z;
        cyc(6);
    endtask
    // two led periods: count lit cycles and rising edges
    task led_chk(input logic [3:0] ph, input int ehi, input int erise);
        int i;
        int hi;
        int rise;
        logic prev;
        @(posedge pclk);
        charge_phase <= ph;
        cyc(8);
        hi = 0;
        rise = 0;
        prev = led_on;
        for (i = 0; i < 32; i++)
        begin
            @(posedge pclk);
            hi += (led_on === 1'b1);
            rise += (led_on === 1'b1 && prev === 1'b0);
            prev = led_on;
        end
        chk_word(hi, ehi);
        chk_word(rise, erise);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {adapter_valid, buck_switching, ship_exit_button} = '0;
        {unplug_cmp_above, chgin_at_reg, chgin_current_low} = '0;
        {headroom_trip, chgin_below_uvlo80, suspend_mode} = '0;
        {deep_suspend_mode, temp_zone, charge_phase} = '0;
        {n_errors, comparisons} = '0;
        cyc(3);
        presetn <= 1'b1;
        rd(`CTSL_A_CFG, 32'h00001, 1'b0);
        rd(`CTSL_A_IRQ, 32'h0, 1'b0);
        wr(12'h100, 32'h0);
        rd(12'h100, 32'h0, 1'b1);
        rd(`CTSL_A_CFG, 32'h00001, 1'b0);
        wr(`CTSL_A_CFG, 32'hffffffff);
        rd(`CTSL_A_CFG, 32'h1ffff, 1'b0);
        chk_bit(warm_current_select, 1'b1);
        chk_bit(cool_voltage_select, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            wr(`CTSL_A_CFG, 32'h1 | (k << 8));
            cyc(2);
            chk_word(led_current_select, k);
        end
        // temperature zones with an adapter and a charge in progress
        wr(`CTSL_A_CFG, 32'h1);
        adapter_valid <= 1'b1;
        charge_phase <= 4'h2;
        zone(3'h0);
        base = n_restart;
        zone(3'h4);
        chk_bit(charge_enable, 1'b0);
        chk_word(n_restart - base, 1);
        rd(`CTSL_A_STAT, 32'h0c9, 1'b0);
        rd(`CTSL_A_IRQ, 32'h1, 1'b0);
        led_chk(4'h2, 16, 4);
        zone(3'h0);
        chk_bit(charge_enable, 1'b1);
        chk_word(n_restart - base, 2);
        wr(`CTSL_A_IRQ, 32'h1);
        rd(`CTSL_A_IRQ, 32'h0, 1'b0);
        zone(3'h2);
        chk_bit(charge_enable, 1'b0);
        rd(`CTSL_A_STAT, 32'h069, 1'b0);
        zone(3'h3);
        chk_bit(cc_warm_use, 1'b1);
        chk_word(cv_drop_code, `CTSL_CVD_A);
        rd(`CTSL_A_STAT, 32'h090, 1'b0);
        wr(`CTSL_A_CFG, 32'h401);
        cyc(3);
        chk_word(cv_drop_code, `CTSL_CVD_B);
        wr(`CTSL_A_CFG, 32'h1);
        zone(3'h1);
        chk_bit(cc_half, 1'b1);
        chk_bit(timer_double, 1'b1);
        chk_bit(cv_cool_use, 1'b1);
        chk_bit(cc_warm_use, 1'b0);
        rd(`CTSL_A_STAT, 32'h030, 1'b0);
        zone(3'h5);
        chk_bit(charge_enable, 1'b0);
        rd(`CTSL_A_STAT, 32'h0e8, 1'b0);
        zone(3'h6);
        chk_bit(charge_enable, 1'b1);
        chk_bit(cc_warm_use, 1'b0);
        rd(`CTSL_A_STAT, 32'h050, 1'b0);
        wr(`CTSL_A_CFG, 32'h0);
        zone(3'h4);
        chk_bit(charge_enable, 1'b1);
        chk_bit(cc_warm_use, 1'b0);
        wr(`CTSL_A_CFG, 32'h21);
        zone(3'h0);
        led_chk(4'h2, 16, 2);
        led_chk(4'hc, 16, 4);
        led_chk(4'h7, 32, 0);
        led_chk(4'h0, 0, 0);
        // ship mode entry and the three ways out
        wr(`CTSL_A_CFG7, 32'h1);
        cyc(2);
        chk_bit(ship_mode, 1'b0);
        adapter_valid <= 1'b0;
        cyc(6);
        wr(`CTSL_A_CFG7, 32'h1);
        cyc(2);
        chk_bit(ship_mode, 1'b1);
        ship_exit_button <= 1'b1;
        cyc(5);
        ship_exit_button <= 1'b0;
        cyc(8);
        chk_bit(ship_mode, 1'b1);
        ship_exit_button <= 1'b1;
        cyc(20);
        chk_bit(ship_mode, 1'b0);
        ship_exit_button <= 1'b0;
        wr(`CTSL_A_CFG7, 32'h1);
        adapter_valid <= 1'b1;
        cyc(6);
        chk_bit(ship_mode, 1'b0);
        adapter_valid <= 1'b0;
        cyc(6);
        wr(`CTSL_A_CFG7, 32'h1);
        zone(3'h5);
        chk_bit(ship_mode, 1'b0);
        zone(3'h0);
        // external switch drive in battery and non-battery modes
        wr(`CTSL_A_CFG, 32'h9);
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b1);
        chk_bit(ext_switch_drive_pin_o, 1'b0);
        adapter_valid <= 1'b1;
        buck_switching <= 1'b1;
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        adapter_valid <= 1'b0;
        buck_switching <= 1'b0;
        wr(`CTSL_A_CFG, 32'h9009);
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        wr(`CTSL_A_CFG, 32'ha009);
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        wr(`CTSL_A_CFG, 32'h1);
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        // power good, high threshold with the long debounce
        wr(`CTSL_A_CFG, 32'h69);
        adapter_valid <= 1'b1;
        unplug_cmp_above <= 1'b1;
        cyc(5);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        cyc(12);
        chk_bit(ext_switch_drive_pin_oe, 1'b1);
        suspend_mode <= 1'b1;
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b1);
        deep_suspend_mode <= 1'b1;
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        {suspend_mode, deep_suspend_mode} <= 2'b00;
        unplug_cmp_above <= 1'b0;
        cyc(16);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        // power good, 5V input with and without adaptive limiting
        wr(`CTSL_A_CFG, 32'h10829);
        cyc(8);
        chk_bit(ext_switch_drive_pin_oe, 1'b1);
        {chgin_at_reg, chgin_current_low} <= 2'b11;
        cyc(5);
        chk_bit(ext_switch_drive_pin_oe, 1'b1);
        cyc(12);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        {chgin_at_reg, chgin_current_low} <= 2'b00;
        wr(`CTSL_A_CFG, 32'h10029);
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b1);
        headroom_trip <= 1'b1;
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        headroom_trip <= 1'b0;
        chgin_below_uvlo80 <= 1'b1;
        cyc(6);
        chk_bit(ext_switch_drive_pin_oe, 1'b0);
        report_and_stop();
    end
endmodule
